// File: hdl/ifs_pkg.sv
// Package: register map, field positions, reset values, phase lengths and state types of the frame sequencer
package ifs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB port
  localparam logic [7:0] ADDR_CAPTURE_CONTROL = 8'h00; // Sequencer enable, mode, trigger polarity
  localparam logic [7:0] ADDR_ANALOG_POWER    = 8'h04; // Analog active bit, cleared for standby
  localparam logic [7:0] ADDR_LINE_TIME       = 8'h08; // Line period in logic clocks
  localparam logic [7:0] ADDR_FRAME_LENGTH    = 8'h0C; // Frame period in line periods
  localparam logic [7:0] ADDR_EXPO_COARSE     = 8'h10; // Exposure, whole line periods
  localparam logic [7:0] ADDR_EXPO_FINE       = 8'h14; // Exposure, extra logic clocks
  localparam logic [7:0] ADDR_OFFSET_COARSE   = 8'h18; // Delay before start overhead, line periods
  localparam logic [7:0] ADDR_READ_LINES      = 8'h1C; // Lines read out per frame
  localparam logic [7:0] ADDR_STATUS          = 8'h20; // Read-only sequencer state

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CC_SEQ_EN_BIT    = 0; // Sequencer enable
  localparam int CC_TRIG_MODE_BIT = 1; // 1: triggered master, 0: free running
  localparam int CC_TRIG_POL_BIT  = 2; // 0: rising edge active
  localparam int CC_IMMEDIATE_BIT = 3; // 1: standby without finishing readout
  localparam int AP_ACTIVE_BIT    = 2; // Analog active, clear to request standby

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0]  CAPTURE_CONTROL_RST = 4'h0;
  localparam logic [2:0]  ANALOG_POWER_RST    = 3'h4;
  localparam logic [15:0] LINE_TIME_RST       = 16'h0040;
  localparam logic [15:0] FRAME_LENGTH_RST    = 16'h0020;
  localparam logic [15:0] EXPO_COARSE_RST     = 16'h0004;
  localparam logic [15:0] EXPO_FINE_RST       = 16'h0000;
  localparam logic [15:0] OFFSET_COARSE_RST   = 16'h0000;
  localparam logic [15:0] READ_LINES_RST      = 16'h0010;

  ////////////////////////////////////////////////////////////////////////////////
  // Overhead phase lengths in logic clocks (defaults of build parameters)
  localparam int START_EXPOSURE_OVERHEAD_CYCLES = 16; // Start overhead, global pixel reset
  localparam int END_EXPOSURE_OVERHEAD_CYCLES = 16; // End overhead, global charge transfer
  localparam int ROT_CYCLES  = 4;  // Row overhead, row select

  ////////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [1:0] {IFS_STANDBY, IFS_CAPTURE, IFS_DRAIN} ifs_mode_t;
  typedef enum logic [2:0] {EX_IDLE, EX_OFFSET, EX_START_EXPOSURE_OVERHEAD, EX_EXPOSE, EX_HOLD, EX_END_EXPOSURE_OVERHEAD} ifs_expo_t;
  typedef enum logic [1:0] {RD_IDLE, RD_ROT, RD_LINE} ifs_read_t;

  // Line periods to logic clocks
  function automatic logic [31:0] ifs_lines_to_clk(input logic [15:0] n, input logic [15:0] lt);
    return 32'(n) * 32'(lt);
  endfunction

endpackage

// File: hdl/ifs_sequencer.sv
// Frame and exposure sequencer with APB register slave and standby control
//
// Contract
// - Clearing analog active bit requests standby
// - Standby waits for readout end unless immediate
// - Global pixel reset and sample, then lines
// - Exposure of next frame overlaps current readout
// - End overhead first, row overhead per line
// - Start overhead suspends line readout
// - Free-running mode captures continuously from registers
// - Frame period counted in whole line periods
// - Output idle during start overhead suspension
// - Programmable line period with enforced minimum
// - Frame period is frame length times line
// - Exposure at least coarse times line plus fine, longer while readout holds the sample
// - Start overhead delayed by coarse offset lines
// - Trigger edge starts register-length exposure
// - Inactive trigger edge ignored, each active edge frames while exposure engine idle
// - Trigger accepted during previous frame readout
// - Exactly one readout per accepted trigger
// - Constant trigger latency: offset plus fixed overhead
// - Trigger synchronised by two flip-flops first
// - Polarity setting selects active trigger edge
// - Sequencer enable enters capture, clear returns standby
`timescale 1ns/1ps
module ifs_sequencer #(
  parameter int START_EXPOSURE_OVERHEAD_CYC = ifs_pkg::START_EXPOSURE_OVERHEAD_CYCLES, // Start overhead length
  parameter int END_EXPOSURE_OVERHEAD_CYC = ifs_pkg::END_EXPOSURE_OVERHEAD_CYCLES, // End overhead length
  parameter int ROT_CYC  = ifs_pkg::ROT_CYCLES   // Row overhead length
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Asynchronous integration trigger
  input  wire logic        trigger_in,
  // Sequencer state and array phases
  output logic             standby_state,
  output logic             capture_active,
  output logic             pixel_reset,
  output logic             pixel_sample,
  output logic             row_select,
  output logic             line_valid,
  output logic [15:0]      row_index
);
  import ifs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]  capture_control, next_capture_control; // Enable, mode, polarity, immediate
  logic [2:0]  analog_power, next_analog_power;       // Analog active in bit 2
  logic [15:0] line_time, next_line_time;             // Line period, clocks
  logic [15:0] frame_length, next_frame_length;       // Frame period, lines
  logic [15:0] expo_coarse, next_expo_coarse;         // Exposure lines
  logic [15:0] expo_fine, next_expo_fine;             // Exposure extra clocks
  logic [15:0] offset_coarse, next_offset_coarse;     // Start delay lines
  logic [15:0] read_lines, next_read_lines;           // Lines per frame
  logic [31:0] next_prdata;                           // Read data for access phase
  logic        next_pslverr;                          // Unmapped address flag
  logic        mapped;                                // Address decodes
  logic        trig_meta, trig_sync, trig_last;       // Trigger synchroniser
  logic        trig_edge;                             // Active edge, one cycle
  logic [15:0] lt_eff;                                // Line period after minimum
  logic [15:0] line_cnt, next_line_cnt;               // Clock within line
  logic [15:0] frame_line, next_frame_line;           // Line within frame
  logic        frame_start;                           // Free-running frame boundary
  ifs_mode_t   mode, next_mode;                       // Standby / capture / drain
  ifs_expo_t   ex_state, next_ex_state;               // Exposure engine
  logic [31:0] ex_cnt, next_ex_cnt;                   // Exposure engine counter
  logic        launch;                                // Start a new exposure
  logic        read_start;                            // End overhead finished
  ifs_read_t   rd_state, next_rd_state;               // Readout engine
  logic [15:0] rd_cnt, next_rd_cnt;                   // Readout phase counter
  logic [15:0] next_row_index;                        // Row being read
  logic        seq_en, trig_mode, trig_pol, immediate, analog_on;

  assign seq_en    = capture_control[CC_SEQ_EN_BIT];
  assign trig_mode = capture_control[CC_TRIG_MODE_BIT];
  assign trig_pol  = capture_control[CC_TRIG_POL_BIT];
  assign immediate = capture_control[CC_IMMEDIATE_BIT];
  assign analog_on = analog_power[AP_ACTIVE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // APB register file: zero wait, data prepared in setup phase
  assign pready = 1'b1;

  always_comb begin
    next_capture_control = capture_control;
    next_analog_power    = analog_power;
    next_line_time       = line_time;
    next_frame_length    = frame_length;
    next_expo_coarse     = expo_coarse;
    next_expo_fine       = expo_fine;
    next_offset_coarse   = offset_coarse;
    next_read_lines      = read_lines;
    next_prdata          = prdata;
    next_pslverr         = pslverr;
    mapped               = 1'b1;
    case (paddr)
      ADDR_CAPTURE_CONTROL: next_prdata = {28'h0000000, capture_control};
      ADDR_ANALOG_POWER:    next_prdata = {29'h0000000, analog_power};
      ADDR_LINE_TIME:       next_prdata = {16'h0000, line_time};
      ADDR_FRAME_LENGTH:    next_prdata = {16'h0000, frame_length};
      ADDR_EXPO_COARSE:     next_prdata = {16'h0000, expo_coarse};
      ADDR_EXPO_FINE:       next_prdata = {16'h0000, expo_fine};
      ADDR_OFFSET_COARSE:   next_prdata = {16'h0000, offset_coarse};
      ADDR_READ_LINES:      next_prdata = {16'h0000, read_lines};
      ADDR_STATUS:          next_prdata = {row_index, 9'h000, 2'(rd_state), 3'(ex_state), 2'(mode)};
      default: begin
        next_prdata = 32'h00000000;
        mapped      = 1'b0;
      end
    endcase
    // Setup phase latches read data and error for the access phase
    if (psel && !penable) begin
      next_pslverr = !mapped;
    end else begin
      next_prdata  = prdata;
    end
    // Write takes effect in the access phase
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_CAPTURE_CONTROL: next_capture_control = pwdata[3:0];
        ADDR_ANALOG_POWER:    next_analog_power    = pwdata[2:0];
        ADDR_LINE_TIME:       next_line_time       = pwdata[15:0];
        ADDR_FRAME_LENGTH:    next_frame_length    = pwdata[15:0];
        ADDR_EXPO_COARSE:     next_expo_coarse     = pwdata[15:0];
        ADDR_EXPO_FINE:       next_expo_fine       = pwdata[15:0];
        ADDR_OFFSET_COARSE:   next_offset_coarse   = pwdata[15:0];
        ADDR_READ_LINES:      next_read_lines      = pwdata[15:0];
        default:              next_read_lines      = read_lines;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_control <= CAPTURE_CONTROL_RST;
      analog_power    <= ANALOG_POWER_RST;
      line_time       <= LINE_TIME_RST;
      frame_length    <= FRAME_LENGTH_RST;
      expo_coarse     <= EXPO_COARSE_RST;
      expo_fine       <= EXPO_FINE_RST;
      offset_coarse   <= OFFSET_COARSE_RST;
      read_lines      <= READ_LINES_RST;
      prdata          <= 32'h00000000;
      pslverr         <= 1'b0;
    end else begin
      capture_control <= next_capture_control;
      analog_power    <= next_analog_power;
      line_time       <= next_line_time;
      frame_length    <= next_frame_length;
      expo_coarse     <= next_expo_coarse;
      expo_fine       <= next_expo_fine;
      offset_coarse   <= next_offset_coarse;
      read_lines      <= next_read_lines;
      prdata          <= next_prdata;
      pslverr         <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser; edge seen only past the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_last <= 1'b0;
    end else begin
      trig_meta <= trigger_in;
      trig_sync <= trig_meta;
      trig_last <= trig_sync;
    end
  end

  // Active edge after polarity; the other edge never fires
  assign trig_edge = (trig_sync ^ trig_pol) && !(trig_last ^ trig_pol);

  ////////////////////////////////////////////////////////////////////////////////
  // Line and frame time base
  assign lt_eff = (line_time > 16'(ROT_CYC)) ? line_time : 16'(ROT_CYC + 1);

  always_comb begin
    next_line_cnt   = 16'h0000;
    next_frame_line = 16'h0000;
    if (mode == IFS_CAPTURE) begin
      next_line_cnt   = line_cnt + 16'h0001;
      next_frame_line = frame_line;
      if (line_cnt >= lt_eff - 16'h0001) begin
        next_line_cnt = 16'h0000;
        // Wrap after frame_length lines
        if (frame_line + 16'h0001 >= frame_length) begin
          next_frame_line = 16'h0000;
        end else begin
          next_frame_line = frame_line + 16'h0001;
        end
      end
    end
  end

  // Time base registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt   <= 16'h0000;
      frame_line <= 16'h0000;
    end else begin
      line_cnt   <= next_line_cnt;
      frame_line <= next_frame_line;
    end
  end

  assign frame_start = (mode == IFS_CAPTURE) && (line_cnt == 16'h0000) && (frame_line == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////////
  // Operating mode: standby, capture, drain
  always_comb begin
    next_mode = mode;
    case (mode)
      IFS_STANDBY: begin
        if (seq_en && analog_on) begin
          next_mode = IFS_CAPTURE;
        end
      end
      IFS_CAPTURE: begin
        // Disable or standby request; immediate skips the drain
        if (!seq_en || !analog_on) begin
          next_mode = immediate ? IFS_STANDBY : IFS_DRAIN;
        end
      end
      IFS_DRAIN: begin
        // Finish the frame in readout, or leave at once if asked
        if (immediate || (rd_state == RD_IDLE && ex_state != EX_END_EXPOSURE_OVERHEAD)) begin
          next_mode = IFS_STANDBY;
        end
      end
      default: next_mode = IFS_STANDBY;
    endcase
  end

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= IFS_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Exposure engine: offset, start overhead, exposure, end overhead
  assign launch = (mode == IFS_CAPTURE) && (trig_mode ? trig_edge : frame_start);

  always_comb begin
    next_ex_state = ex_state;
    next_ex_cnt   = ex_cnt;
    read_start    = 1'b0;
    case (ex_state)
      EX_IDLE: begin
        // Runs independent of readout, so it overlaps the previous frame
        if (launch) begin
          if (offset_coarse == 16'h0000) begin
            next_ex_state = EX_START_EXPOSURE_OVERHEAD;
            next_ex_cnt   = 32'(START_EXPOSURE_OVERHEAD_CYC);
          end else begin
            next_ex_state = EX_OFFSET;
            next_ex_cnt   = ifs_lines_to_clk(offset_coarse, lt_eff);
          end
        end
      end
      EX_OFFSET: begin
        next_ex_cnt = ex_cnt - 32'h00000001;
        if (ex_cnt <= 32'h00000001) begin
          next_ex_state = EX_START_EXPOSURE_OVERHEAD;
          next_ex_cnt   = 32'(START_EXPOSURE_OVERHEAD_CYC);
        end
      end
      EX_START_EXPOSURE_OVERHEAD: begin
        // Global pixel reset across the array
        next_ex_cnt = ex_cnt - 32'h00000001;
        if (ex_cnt <= 32'h00000001) begin
          next_ex_state = EX_EXPOSE;
          next_ex_cnt   = ifs_lines_to_clk(expo_coarse, lt_eff) + 32'(expo_fine);
        end
      end
      EX_EXPOSE: begin
        next_ex_cnt = ex_cnt - 32'h00000001;
        if (ex_cnt <= 32'h00000001) begin
          // Storage free: sample at once, so exposure is exactly the programmed length
          if (rd_state == RD_IDLE) begin
            next_ex_state = EX_END_EXPOSURE_OVERHEAD;
            next_ex_cnt   = 32'(END_EXPOSURE_OVERHEAD_CYC);
          end else begin
            next_ex_state = EX_HOLD;
          end
        end
      end
      EX_HOLD: begin
        // Storage node busy until the previous frame is read out
        if (rd_state == RD_IDLE) begin
          next_ex_state = EX_END_EXPOSURE_OVERHEAD;
          next_ex_cnt   = 32'(END_EXPOSURE_OVERHEAD_CYC);
        end
      end
      EX_END_EXPOSURE_OVERHEAD: begin
        // Global sample, then the frame readout begins
        next_ex_cnt = ex_cnt - 32'h00000001;
        if (ex_cnt <= 32'h00000001) begin
          next_ex_state = EX_IDLE;
          read_start    = 1'b1;
        end
      end
      default: next_ex_state = EX_IDLE;
    endcase
    // Leaving capture abandons the exposure; a running sample completes in drain only, standby stops it
    if (mode == IFS_STANDBY || (mode == IFS_DRAIN && ex_state != EX_END_EXPOSURE_OVERHEAD)) begin
      next_ex_state = EX_IDLE;
      next_ex_cnt   = 32'h00000000;
    end
  end

  // Exposure registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_state <= EX_IDLE;
      ex_cnt   <= 32'h00000000;
    end else begin
      ex_state <= next_ex_state;
      ex_cnt   <= next_ex_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Readout engine: row overhead then line data, held during start overhead
  always_comb begin
    next_rd_state  = rd_state;
    next_rd_cnt    = rd_cnt;
    next_row_index = row_index;
    case (rd_state)
      RD_IDLE: begin
        if (read_start) begin
          next_rd_state  = RD_ROT;
          next_rd_cnt    = 16'(ROT_CYC);
          next_row_index = 16'h0000;
        end
      end
      RD_ROT: begin
        if (ex_state != EX_START_EXPOSURE_OVERHEAD) begin
          next_rd_cnt = rd_cnt - 16'h0001;
          if (rd_cnt <= 16'h0001) begin
            next_rd_state = RD_LINE;
            next_rd_cnt   = lt_eff - 16'(ROT_CYC);
          end
        end
      end
      RD_LINE: begin
        if (ex_state != EX_START_EXPOSURE_OVERHEAD) begin
          next_rd_cnt = rd_cnt - 16'h0001;
          if (rd_cnt <= 16'h0001) begin
            if (row_index + 16'h0001 >= read_lines) begin
              next_rd_state = RD_IDLE;
            end else begin
              next_rd_state  = RD_ROT;
              next_rd_cnt    = 16'(ROT_CYC);
              next_row_index = row_index + 16'h0001;
            end
          end
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
    // Standby stops the readout
    if (mode == IFS_STANDBY) begin
      next_rd_state = RD_IDLE;
      next_rd_cnt   = 16'h0000;
    end
  end

  // Readout registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state  <= RD_IDLE;
      rd_cnt    <= 16'h0000;
      row_index <= 16'h0000;
    end else begin
      rd_state  <= next_rd_state;
      rd_cnt    <= next_rd_cnt;
      row_index <= next_row_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase outputs
  assign standby_state  = (mode == IFS_STANDBY);
  assign capture_active = (mode == IFS_CAPTURE);
  assign pixel_reset    = (ex_state == EX_START_EXPOSURE_OVERHEAD);
  assign pixel_sample   = (ex_state == EX_END_EXPOSURE_OVERHEAD);
  assign row_select     = (rd_state == RD_ROT) && (ex_state != EX_START_EXPOSURE_OVERHEAD);
  assign line_valid     = (rd_state == RD_LINE) && (ex_state != EX_START_EXPOSURE_OVERHEAD);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_line_idle_start_exposure_overhead: assert property (@(posedge pclk) disable iff (!presetn)
    pixel_reset |-> !line_valid && !row_select) else $error("line active during start overhead");

  a_end_exposure_overhead_then_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_state == RD_IDLE && next_rd_state == RD_ROT) |-> pixel_sample) else $error("readout began without end overhead");

  a_rot_before_line: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rd_state == RD_LINE) |-> $past(rd_state) == RD_ROT) else $error("line without row overhead");

  a_idle_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (capture_active && trig_mode && !trig_edge && ex_state == EX_IDLE && mode == next_mode)
    |=> ex_state == EX_IDLE) else $error("exposure started without active edge");

  a_trig_latency: assert property (@(posedge pclk) disable iff (!presetn)
    (capture_active && trig_mode && trig_edge && ex_state == EX_IDLE && offset_coarse == 16'h0000 && seq_en && analog_on)
    |=> pixel_reset ##0 $past(trig_sync, 1) != $past(trig_last, 1)) else $error("trigger latency not fixed");

  a_standby_now: assert property (@(posedge pclk) disable iff (!presetn)
    (capture_active && !analog_on && immediate) |=> standby_state) else $error("immediate standby not taken");

  a_drain_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == IFS_DRAIN && !immediate && rd_state != RD_IDLE) |=> !standby_state) else $error("standby before readout end");

  a_enable_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (standby_state && seq_en && analog_on) |=> capture_active) else $error("enable did not enter capture");

endmodule // ifs_sequencer

// File: tb/ifs_host_model.sv
// Host model: drives the integration trigger pin as a pulse
`timescale 1ns/1ps
module ifs_host_model (
  // Clock, reset and pulse request
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  // Trigger pin
  output logic      trigger_in
);
  logic [4:0] width; // Pulse cycles left
  // Rising edge on request, falling edge some cycles later
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) width <= 5'h00;
    else if (fire) width <= 5'h14;
    else if (width != 5'h00) width <= width - 5'h01;
  assign trigger_in = (width != 5'h00);
endmodule // ifs_host_model

// File: tb/integration_frame_sequencer_tb.sv
// Testbench: registers, free-run, standby and triggered capture
`timescale 1ns/1ps
module integration_frame_sequencer_tb;
  import ifs_pkg::*;
  localparam int SF = 6, EF = 5, RT = 3, LT = 8; // Phase and line lengths
  logic pclk, presetn, psel, penable, pwrite, fire, pe, pr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, trigger_in, standby_state, capture_active;
  logic pixel_reset, pixel_sample, row_select, line_valid;
  logic [15:0] row_index;
  logic [4:0] mon; // Watched levels
  int mismatches = 0, checked = 0, n, l1, r0, rises = 0;
  assign mon = {standby_state, line_valid, row_select, pixel_sample, pixel_reset};
  ifs_sequencer #(.START_EXPOSURE_OVERHEAD_CYC(SF), .END_EXPOSURE_OVERHEAD_CYC(EF), .ROT_CYC(RT)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .trigger_in, .standby_state, .capture_active,
    .pixel_reset, .pixel_sample, .row_select, .line_valid, .row_index);
  ifs_host_model i_host (.pclk, .presetn, .fire, .trigger_in);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until a watched level is reached
  task automatic wt(input int i, input logic v, output int c);
    c = 0;
    while (mon[i] !== v && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    chk("wait_reached", 1, mon[i] === v);
  endtask
  task automatic pulse(output int c);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wt(0, 1, c);
  endtask
  // Readout idle during global phases, frame starts counted
  always @(posedge pclk) begin
    if (pixel_reset === 1'b1 || pixel_sample === 1'b1) chk("readout_idle", 0, {row_select, line_valid});
    if (pixel_reset === 1'b1 && pr !== 1'b1) rises++;
    pr = pixel_reset;
  end
  task automatic t_regs;
    apb(0, ADDR_ANALOG_POWER, 0);
    chk("analog_power", 32'(ANALOG_POWER_RST), rd);
    apb(0, ADDR_LINE_TIME, 0);
    chk("line_time", 32'(LINE_TIME_RST), rd);
    apb(0, 8'h40, 0);
    chk("unmapped_err", 1, pe);
    apb(0, ADDR_STATUS, 0);
    chk("status_idle", 0, rd);
    chk("standby_reset", 1, standby_state);
  endtask
  task automatic t_free;
    apb(1, ADDR_LINE_TIME, LT);
    apb(1, ADDR_EXPO_COARSE, 1);
    apb(1, ADDR_EXPO_FINE, 2);
    apb(1, ADDR_READ_LINES, 2);
    apb(0, ADDR_EXPO_FINE, 0);
    chk("expo_fine", 2, rd);
    apb(1, ADDR_CAPTURE_CONTROL, 1);
    wt(0, 1, n);
    wt(0, 0, n);
    chk("start_exposure_overhead_len", SF, n);
    wt(1, 1, n);
    chk("expose_len", LT + 2, n);
    wt(1, 0, n);
    chk("end_exposure_overhead_len", EF, n);
    wt(2, 1, n);
    wt(2, 0, n);
    chk("rot_len", RT, n);
    wt(3, 0, n);
    chk("line_len", LT - RT, n);
    chk("row_next", 1, row_index);
    chk("capture_on", 1, capture_active);
    wt(0, 1, n);
    wt(0, 0, n);
    wt(0, 1, l1);
    chk("frame_period", 32'(FRAME_LENGTH_RST) * LT, n + l1);
  endtask
  task automatic t_stby;
    wt(2, 1, n);
    apb(1, ADDR_CAPTURE_CONTROL, 0);
    wt(4, 1, n);
    chk("drain_wait", 1, n > 2);
    apb(1, ADDR_CAPTURE_CONTROL, 9);
    wt(2, 1, n);
    apb(1, ADDR_ANALOG_POWER, 0);
    wt(4, 1, n);
    chk("immediate_standby", 1, n <= 2);
  endtask
  task automatic t_trig;
    apb(1, ADDR_CAPTURE_CONTROL, 3);
    apb(1, ADDR_ANALOG_POWER, 4);
    r0 = rises;
    repeat (400) @(posedge pclk);
    chk("no_trigger_idle", r0, rises);
    pulse(l1);
    wt(2, 1, n);
    pulse(n);
    chk("overlap_latency", l1, n);
    repeat (600) @(posedge pclk);
    chk("one_per_trigger", r0 + 2, rises);
    apb(1, ADDR_OFFSET_COARSE, 2);
    pulse(n);
    chk("offset_latency", l1 + 2 * LT, n);
    repeat (100) @(posedge pclk);
    apb(1, ADDR_CAPTURE_CONTROL, 7);
    pulse(n);
    chk("falling_active", l1 + 2 * LT + 20, n);
  endtask
  // Shutdown: disable, standby, hard reset with clock kept running, then restart
  task automatic t_down;
    apb(1, ADDR_CAPTURE_CONTROL, 0);
    apb(1, ADDR_ANALOG_POWER, 0);
    wt(4, 1, n);
    chk("down_standby", 1, standby_state);
    presetn <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("reset_capture", 0, capture_active);
    repeat (5000) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CAPTURE_CONTROL, 0);
    chk("control_reset", 32'(CAPTURE_CONTROL_RST), rd);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, fire, pr} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_free;
    t_stby;
    t_trig;
    t_down;
    summarize;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    summarize;
  end
endmodule // integration_frame_sequencer_tb
